// file: testbench.sv
`timescale 1ns/1ps
module testbench;
   import wwd_pkg::*;
   // Short prescale keeps each expiry within a few dozen cycles
   localparam int unsigned PR = 16;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, q1;
   logic [31:0] mismatches = 32'h0;
   logic [31:0] num_checks = 32'h0;
   logic [31:0] pulses = 32'h0;
   logic hw_opt, halt_opt, halt_req, wake, long_sel, halt_granted, reset_request, irq;

   wwd_top #(.PRESC(PR), .RESUME_LONG_CYC(64)) wwd_top_i (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_activation_option(hw_opt), .reset_on_halt_option(halt_opt),
      .halt_request(halt_req), .wake_interrupt(wake), .resume_long_select(long_sel),
      .halt_granted(halt_granted), .reset_request(reset_request), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Counts high cycles, so a stretched request shows up as extra pulses
   always @(posedge clk) begin
      if (reset_request === 1'b1) begin
         pulses <= pulses + 32'h1;
      end
   end

   task complete_run;
      $display("num_checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 32'h0 && num_checks > 32'h0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks = num_checks + 32'h1;
      if (got !== exp) begin
         mismatches = mismatches + 32'h1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      chk({30'h0, pready, pslverr}, 32'h2);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // Status must match, then it is cleared by writing ones
   task ev(input logic [31:0] st, input logic [31:0] n);
      rd(ADDR_STATUS, st);
      chk(pulses, n);
      wr(ADDR_STATUS, 32'hF);
   endtask

   task do_reset(input logic hw);
      hw_opt <= hw;
      rst_b <= 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask

   task halt_pulse(input logic opt);
      halt_opt <= opt;
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(halt_granted, !opt);
      @(posedge clk);
   endtask

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {hw_opt, halt_opt, halt_req, wake, long_sel} = 5'h01;
      @(posedge clk);
      do_reset(1'b0);
      rd(ADDR_CTRL, 32'h7F);
      rd(ADDR_WINDOW, 32'h7F);
      rd(ADDR_MASK, 32'h0);
      rd(12'h010, 32'h0);
      wr(ADDR_MASK, 32'h1);
      wr(ADDR_CTRL, 32'h41);
      repeat (3 * PR) @(posedge clk);
      apb(1'b0, ADDR_CTRL, 32'h0, q);
      chk(q[7:0] >= 8'h3D && q[7:0] <= 8'h3F, 1'b1);
      ev(32'h0, 32'h0);
      wr(ADDR_CTRL, 32'hC1);
      repeat (3 * PR) @(posedge clk);
      @(negedge clk);
      chk(irq, 1'b1);
      @(posedge clk);
      ev(32'h1, 32'h1);
      @(negedge clk);
      chk(irq, 1'b0);
      @(posedge clk);
      wr(ADDR_WINDOW, 32'h50);
      wr(ADDR_CTRL, 32'hC8);
      wr(ADDR_CTRL, 32'hC8);
      ev(32'h0, 32'h1);
      wr(ADDR_CTRL, 32'hFF);
      wr(ADDR_CTRL, 32'hFF);
      @(negedge clk);
      chk(irq, 1'b0); // Masked source keeps the line low
      @(posedge clk);
      ev(32'h2, 32'h2);
      wr(ADDR_WINDOW, 32'h7F);
      wr(ADDR_CTRL, 32'h80);
      wr(ADDR_CTRL, 32'hFF);
      ev(32'h4, 32'h3);
      halt_pulse(1'b1);
      ev(32'h8, 32'h4);
      wr(ADDR_CTRL, 32'hFF);
      halt_pulse(1'b0);
      repeat (PR + 4) @(posedge clk);
      apb(1'b0, ADDR_CTRL, 32'h0, q1);
      repeat (3 * PR) @(posedge clk);
      rd(ADDR_CTRL, q1);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (40) @(posedge clk);
      rd(ADDR_CTRL, q1);
      repeat (64) @(posedge clk);
      apb(1'b0, ADDR_CTRL, 32'h0, q);
      chk(q[6:0] < q1[6:0], 1'b1);
      ev(32'h0, 32'h4);
      do_reset(1'b1);
      rd(ADDR_STATUS, 32'h0);
      wr(ADDR_CTRL, 32'h41);
      repeat (3 * PR) @(posedge clk);
      ev(32'h1, 32'h5);
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches = mismatches + 32'h1;
      complete_run;
   end
endmodule

// file: wwd_pkg.sv
package wwd_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned PRESC_DIV = 16384;
   localparam int unsigned RESUME_SHORT = 256;
   localparam int unsigned RESUME_LONG = 4096;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_WINDOW = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_MASK = 12'h00C;
   localparam logic [6:0] CNT_RESET = 7'h7F;
   localparam logic [6:0] WIN_RESET = 7'h7F;
   localparam logic [6:0] CNT_EXPIRE = 7'h40;
   localparam int unsigned TOP_BIT = 6;
   localparam int unsigned ACT_BIT = 7;
   localparam int unsigned ST_EXPIRE = 0;
   localparam int unsigned ST_WINDOW = 1;
   localparam int unsigned ST_SOFT = 2;
   localparam int unsigned ST_HALT = 3;
   localparam int unsigned ST_W = 4;
   typedef enum logic [1:0] {WWD_RUN, WWD_HALT_DEC, WWD_STOPPED, WWD_RESUME} wwd_halt_t;
endpackage

// file: wwd_presc.sv
`timescale 1ns/1ps
module wwd_presc
   import wwd_pkg::*;
#(
   parameter int unsigned DIV = PRESC_DIV
) (
   input wire logic clk,
   input wire logic rst_b,
   wwd_presc_if.presc pi
);
   logic [$clog2(DIV)-1:0] cnt_r;
   // Never cleared by counter writes, hence the min/max timeout spread
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else if (pi.run) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
   assign pi.tick = pi.run && (cnt_r == $clog2(DIV)'(DIV - 1));
endmodule

// file: wwd_presc_if.sv
`timescale 1ns/1ps
interface wwd_presc_if;
   logic run;
   logic tick;
   modport owner (output run, input tick);
   modport presc (input run, output tick);
endinterface

// file: wwd_top.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module wwd_top
   import wwd_pkg::*;
#(
   parameter int unsigned PRESC = PRESC_DIV,
   parameter int unsigned RESUME_LONG_CYC = RESUME_LONG
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_activation_option,
   input wire logic reset_on_halt_option,
   input wire logic halt_request,
   input wire logic wake_interrupt,
   input wire logic resume_long_select,
   output logic halt_granted,
   output logic reset_request,
   output logic irq
);
   import wwd_pkg::*;

   logic [6:0] counter_r;
   logic [6:0] window_limit_r;
   logic activation_bit_r;
   logic [ST_W-1:0] status_r;
   logic [ST_W-1:0] mask_r;
   logic [ST_W-1:0] events;
   wwd_halt_t halt_r;
   logic [12:0] resume_r;
   logic active;
   logic wr;
   logic rd;
   logic ctrl_wr;
   logic tick;
   logic expire_ev;
   logic window_ev;
   logic soft_ev;
   logic halt_ev;
   logic halt_plain;
   wwd_presc_if pif ();

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      return a == b;
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign ctrl_wr = wr && hit(paddr, ADDR_CTRL);
   assign active = hw_activation_option || activation_bit_r;

   // Halt stops the prescaler too so that exactly one decrement happens
   assign pif.run = (halt_r != WWD_STOPPED) && (halt_r != WWD_RESUME);
   assign tick = pif.tick;
   wwd_presc #(.DIV(PRESC)) u_presc (
      .clk(clk),
      .rst_b(rst_b),
      .pi(pif)
   );

   assign halt_plain = halt_request && !(active && reset_on_halt_option);
   assign expire_ev = active && tick && (counter_r == CNT_EXPIRE);
   // Window compare sees the count before the reload lands
   assign window_ev = active && ctrl_wr && (counter_r > window_limit_r);
   assign soft_ev = ctrl_wr && (pwdata[ACT_BIT] || active) && !pwdata[TOP_BIT];
   assign halt_ev = active && reset_on_halt_option && halt_request && (halt_r == WWD_RUN);
   always_comb begin
      events = '0;
      events[ST_EXPIRE] = expire_ev;
      events[ST_WINDOW] = window_ev;
      events[ST_SOFT] = soft_ev;
      events[ST_HALT] = halt_ev;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reset_request <= 1'b0;
      end else begin
         reset_request <= |events;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         counter_r <= CNT_RESET;
      end else if (ctrl_wr) begin
         counter_r <= pwdata[TOP_BIT:0];
      end else if (tick) begin
         counter_r <= counter_r - 7'h01;
      end
   end

   // Only reset can clear activation, so a stray write cannot disarm it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         activation_bit_r <= 1'b0;
      end else if (ctrl_wr && pwdata[ACT_BIT]) begin
         activation_bit_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         window_limit_r <= WIN_RESET;
      end else if (wr && hit(paddr, ADDR_WINDOW)) begin
         window_limit_r <= pwdata[TOP_BIT:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_r <= '0;
      end else if (wr && hit(paddr, ADDR_MASK)) begin
         mask_r <= pwdata[ST_W-1:0];
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_r <= '0;
      end else if (wr && hit(paddr, ADDR_STATUS)) begin
         status_r <= (status_r & ~pwdata[ST_W-1:0]) | events;
      end else begin
         status_r <= status_r | events;
      end
   end
   assign irq = |(status_r & mask_r);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         halt_r <= WWD_RUN;
         resume_r <= '0;
      end else begin
         unique case (halt_r)
            WWD_RUN: begin
               if (halt_plain) begin
                  halt_r <= WWD_HALT_DEC;
               end
            end
            WWD_HALT_DEC: begin
               if (tick) begin
                  halt_r <= WWD_STOPPED;
               end
            end
            WWD_STOPPED: begin
               if (wake_interrupt) begin
                  halt_r <= WWD_RESUME;
                  resume_r <= resume_long_select ? 13'(RESUME_LONG_CYC - 1)
                                                 : 13'(RESUME_SHORT - 1);
               end
            end
            WWD_RESUME: begin
               if (resume_r == '0) begin
                  halt_r <= WWD_RUN;
               end else begin
                  resume_r <= resume_r - 13'h0001;
               end
            end
         endcase
      end
   end
   assign halt_granted = (halt_r == WWD_HALT_DEC) || (halt_r == WWD_STOPPED);

   // Latched in setup so the word stands through the access phase
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prdata <= '0;
      end else if (rd) begin
         prdata <= '0;
         if (hit(paddr, ADDR_CTRL)) begin
            prdata[ACT_BIT:0] <= {activation_bit_r, counter_r};
         end else if (hit(paddr, ADDR_WINDOW)) begin
            prdata[TOP_BIT:0] <= window_limit_r;
         end else if (hit(paddr, ADDR_STATUS)) begin
            prdata[ST_W-1:0] <= status_r;
         end else if (hit(paddr, ADDR_MASK)) begin
            prdata[ST_W-1:0] <= mask_r;
         end
      end
   end

   // Reset sources
   a_expire_reset: assert property (@(posedge clk) disable iff (!rst_b)
      active && tick && counter_r == CNT_EXPIRE |=> reset_request)
      else $error("expiry gave no reset");
   a_window_reset: assert property (@(posedge clk) disable iff (!rst_b)
      active && ctrl_wr && counter_r > window_limit_r |=> reset_request)
      else $error("early reload gave no reset");
   a_window_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      ctrl_wr && pwdata[TOP_BIT] && counter_r <= window_limit_r && !tick && !halt_request
      |=> !reset_request)
      else $error("reload inside window gave reset");
   a_soft_reset: assert property (@(posedge clk) disable iff (!rst_b)
      ctrl_wr && pwdata[ACT_BIT] && !pwdata[TOP_BIT] |=> reset_request)
      else $error("soft reset missing");
   a_hw_active: assert property (@(posedge clk) disable iff (!rst_b)
      hw_activation_option && ctrl_wr && !pwdata[TOP_BIT] |=> reset_request)
      else $error("hardware option ignored");
   a_halt_reset: assert property (@(posedge clk) disable iff (!rst_b)
      halt_request && active && reset_on_halt_option && halt_r == WWD_RUN
      |=> reset_request)
      else $error("halt reset missing");
   a_no_idle_reset: assert property (@(posedge clk) disable iff (!rst_b)
      !active && !(ctrl_wr && pwdata[ACT_BIT]) |=> !reset_request)
      else $error("reset while inactive");
   a_reset_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      !(|events) |=> !reset_request)
      else $error("reset request stretched");

   // Counter and activation
   a_count_down: assert property (@(posedge clk) disable iff (!rst_b)
      tick && !ctrl_wr |=> counter_r == $past(counter_r) - 7'h01)
      else $error("counter did not decrement");
   a_count_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !tick && !ctrl_wr |=> $stable(counter_r))
      else $error("counter moved without a tick");
   a_tick_gap: assert property (@(posedge clk) disable iff (!rst_b)
      tick |=> (!tick) [*8])
      else $error("prescaler ticks too close");
   a_act_sticky: assert property (@(posedge clk) disable iff (!rst_b)
      activation_bit_r |=> activation_bit_r)
      else $error("activation cleared");
   a_act_by_write: assert property (@(posedge clk) disable iff (!rst_b)
      !activation_bit_r && !(ctrl_wr && pwdata[ACT_BIT]) |=> !activation_bit_r)
      else $error("activation set without a write");

   // Halt sequence
   a_halt_frozen: assert property (@(posedge clk) disable iff (!rst_b)
      halt_r == WWD_STOPPED && !ctrl_wr |=> $stable(counter_r))
      else $error("counter moved in halt");
   a_resume_frozen: assert property (@(posedge clk) disable iff (!rst_b)
      halt_r == WWD_RESUME && !ctrl_wr |=> $stable(counter_r))
      else $error("counter moved before resume");
   a_halt_enter: assert property (@(posedge clk) disable iff (!rst_b)
      halt_r == WWD_RUN && halt_plain |=> halt_granted)
      else $error("halt not granted");
   a_halt_one_step: assert property (@(posedge clk) disable iff (!rst_b)
      halt_r == WWD_HALT_DEC && tick |=> halt_r == WWD_STOPPED)
      else $error("halt took more than one step");
   a_resume_wait: assert property (@(posedge clk) disable iff (!rst_b)
      halt_r == WWD_STOPPED && wake_interrupt |=> (halt_r == WWD_RESUME) [*8])
      else $error("counting resumed too early");
   a_halt_no_reset: assert property (@(posedge clk) disable iff (!rst_b)
      halt_plain && !ctrl_wr && !tick |=> !reset_request)
      else $error("plain halt gave reset");

   // Status and interrupt
   a_event_flag: assert property (@(posedge clk) disable iff (!rst_b)
      (|events) |=> (|status_r))
      else $error("event not flagged");
   a_status_hold: assert property (@(posedge clk) disable iff (!rst_b)
      status_r[ST_EXPIRE] && !(wr && hit(paddr, ADDR_STATUS)) |=> status_r[ST_EXPIRE])
      else $error("status flag lost");
   a_irq_masked: assert property (@(posedge clk) disable iff (!rst_b)
      !(|mask_r) |-> !irq)
      else $error("masked status raised irq");

   // Register reads
   a_read_counter: assert property (@(posedge clk) disable iff (!rst_b)
      rd && hit(paddr, ADDR_CTRL) |=> prdata[TOP_BIT:0] == $past(counter_r))
      else $error("counter read wrong");
   a_read_window: assert property (@(posedge clk) disable iff (!rst_b)
      rd && hit(paddr, ADDR_WINDOW) |=> prdata[TOP_BIT:0] == $past(window_limit_r))
      else $error("window read wrong");
   a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
      rd && !hit(paddr, ADDR_CTRL) && !hit(paddr, ADDR_WINDOW)
      && !hit(paddr, ADDR_STATUS) && !hit(paddr, ADDR_MASK) |=> prdata == '0)
      else $error("unmapped read not zero");

   c_expire: cover property (@(posedge clk) disable iff (!rst_b) expire_ev);
   c_window: cover property (@(posedge clk) disable iff (!rst_b) window_ev);
   c_soft: cover property (@(posedge clk) disable iff (!rst_b) soft_ev);
   c_halt_reset: cover property (@(posedge clk) disable iff (!rst_b) halt_ev);
   c_resume: cover property (@(posedge clk) disable iff (!rst_b)
      halt_r == WWD_RESUME ##1 halt_r == WWD_RUN);
endmodule
